// ==== common/rrx_defs.svh ====
`ifndef RRX_DEFS_SVH
`define RRX_DEFS_SVH
`define RRX_ADR_PROT 8'h01
`define RRX_ADR_RXOPT 8'h03
`define RRX_ADR_NORESP 8'h07
`define RRX_ADR_RXWAIT 8'h08
`define RRX_ADR_IRQ 8'h0c
`define RRX_ADR_LENH 8'h1a
`define RRX_ADR_LENL 8'h1b
`define RRX_ADR_TXLEN2 8'h1e
`define RRX_ADR_FIFO 8'h1f
`define RRX_ADR_RN16H 8'h20
`define RRX_ADR_RN16L 8'h21
`define RRX_ADR_CMD 8'h22
`define RRX_ADR_FSTAT 8'h23
`define RRX_PROT_RST 8'h06
`define RRX_RXWAIT_DEF 8'h04
`define RRX_NORESP_DEF 8'h10
`define RRX_WAIT_UNIT_NS 6400
`define RRX_NORESP_UNIT_NS 25600
`define RRX_CLK_NS 4
`define RRX_WAIT_CYC (`RRX_WAIT_UNIT_NS / `RRX_CLK_NS)
`define RRX_NORESP_CYC (`RRX_NORESP_UNIT_NS / `RRX_CLK_NS)
`define RRX_IRQ_FIFO 7
`define RRX_IRQ_END 6
`define RRX_IRQ_NORESP 5
`define RRX_IRQ_CRC 4
`define RRX_IRQ_HDR 3
`define RRX_IRQ_FMT 2
`define RRX_IRQ_EOF 1
`define RRX_IRQ_PRE 0
`define RRX_CRC_INIT 16'hffff
`define RRX_CRC_POLY 16'h1021
`define RRX_CRC_RES 16'h1d0f
`define RRX_FSYNC 16'h0f
`define RRX_FIFO_DEPTH 24
`define RRX_FIFO_WARN 18
`define RRX_PAUSE_BITS 8'h04
`define RRX_LONG_PRE 4'hc
`define RRX_SHORT_PRE 4'h4
`endif

// ==== common/rrx_pkg.sv ====
package rrx_pkg;
  typedef enum logic [1:0] {
    RRX_FM0,
    RRX_MIL2,
    RRX_MIL4,
    RRX_MIL8
  } rrx_coding_type;
  typedef enum logic [2:0] {
    RRX_IDLE,
    RRX_WAIT,
    RRX_SEEK,
    RRX_DATA,
    RRX_DONE
  } rrx_state_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rrx_bus_type;
  typedef struct packed {
    logic bit_val;
    logic bit_stb;
  } rrx_bit_type;
endpackage

// ==== rtl/rrx_framer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rrx_defs.svh"
module rrx_framer #(
  parameter int WAIT_CYC = `RRX_WAIT_CYC,
  parameter int NORESP_CYC = `RRX_NORESP_CYC,
  parameter int DEPTH = `RRX_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire rrx_pkg::rrx_bus_type bus,
  output logic [7:0] rdata,
  input wire logic sub_i,
  input wire logic sub_q,
  input wire logic tx_done,
  input wire logic slot_start,
  input wire logic direct_en,
  output logic irq,
  output logic direct_out_a,
  output logic direct_out_b,
  output logic [15:0] ack_rn16
);
  import rrx_pkg::*;

  logic [1:0] si_r, sq_r;
  logic [7:0] prot_r, rxopt_r, noresp_r, rxwait_r, irq_r, lenh_r, lenl_r;
  logic [2:0] last_byte_valid_bits;
  logic [15:0] rn16_r, len_force_r, crc_r, shift_r;
  logic [7:0] mem [DEPTH];
  logic [4:0] wp_r, rp_r, cnt_r;
  rrx_state_type state_r;
  logic [15:0] tmr_r, nr_tmr_r;
  logic [7:0] units_r, nr_units_r;
  logic [7:0] per_r, phase_r, idle_r;
  logic last_r, bit_val, bit_stb;
  logic [3:0] pre_cnt_r;
  logic [2:0] bpos_r;
  logic [7:0] byte_r;
  logic [15:0] nbits_r, nbytes_r;
  logic [15:0] hold_r;
  logic rn16_cmd_r, nr_run_r;
  logic [7:0] ev;
  logic wr_fifo, rd_fifo;
  logic [7:0] wr_byte;

  wire logic two_byte_header_irq_enable = lenh_r[7];
  wire logic crc_off = prot_r[7];
  wire logic dir_sel = prot_r[6];
  wire rrx_coding_type coding = rrx_coding_type'(prot_r[3:2]);
  wire logic [3:0] link_freq_select = rxopt_r[3:0];
  wire logic [15:0] len_prog = {1'b0, lenh_r[6:0], lenl_r};
  wire logic [15:0] len_eff = (len_force_r != 16'h0000) ? len_force_r : len_prog;
  // an rn16 reply carries no crc, so a forced 16 bit length skips the check
  wire logic no_crc = crc_off || len_force_r == 16'd16;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `RRX_CRC_POLY : 16'h0000);
  endfunction

  // raw channels come from pins and pass two flops first
  always_ff @(posedge sys_clk) begin
    si_r <= {si_r[0], sub_i};
    sq_r <= {sq_r[0], sub_q};
  end

  // decoder: symbol period is set by link rate, miller stretches it by its factor
  always_comb begin
    bit_stb = 1'b0;
    bit_val = 1'b0;
    if (state_r == RRX_SEEK || state_r == RRX_DATA) begin
      if (phase_r == per_r) begin
        bit_stb = 1'b1;
        bit_val = (idle_r > (per_r >> 1)) ? 1'b1 : 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_r == RRX_WAIT || state_r == RRX_IDLE) begin
      phase_r <= 8'h00;
      idle_r <= 8'h00;
      last_r <= 1'b0;
      per_r <= 8'h08;
    end else begin
      per_r <= 8'(({4'h0, link_freq_select} + 8'h04) << prot_r[3:2]);
      last_r <= si_r[1];
      if (phase_r == per_r) begin
        phase_r <= 8'h00;
        idle_r <= 8'h00;
      end else begin
        phase_r <= phase_r + 8'h01;
        if (last_r == si_r[1])
          idle_r <= idle_r + 8'h01;
      end
    end
  end

  // rx wait timer runs only while the decoders are held off
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_r != RRX_WAIT) begin
      tmr_r <= 16'h0000;
      units_r <= 8'h00;
    end else if (tmr_r == 16'(WAIT_CYC - 1)) begin
      tmr_r <= 16'h0000;
      units_r <= units_r + 8'h01;
    end else begin
      tmr_r <= tmr_r + 16'h0001;
    end
  end

  // own count for no-response: slot start may fall inside rx wait, so no sharing
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nr_run_r <= 1'b0;
      nr_tmr_r <= 16'h0000;
      nr_units_r <= 8'h00;
    end else if (slot_start) begin
      nr_run_r <= 1'b1;
      nr_tmr_r <= 16'h0000;
      nr_units_r <= 8'h00;
    end else if (state_r == RRX_DATA || ev[`RRX_IRQ_NORESP]) begin
      nr_run_r <= 1'b0;
    end else if (nr_run_r && nr_tmr_r == 16'(NORESP_CYC - 1)) begin
      nr_tmr_r <= 16'h0000;
      nr_units_r <= nr_units_r + 8'h01;
    end else if (nr_run_r) begin
      nr_tmr_r <= nr_tmr_r + 16'h0001;
    end
  end

  // header mode keeps bit 0 quiet so its status codes read 48, 42 and 4a
  wire logic pre_found = state_r == RRX_SEEK && bit_stb && pre_cnt_r == ((rxopt_r[7] ||
      !(coding == RRX_MIL4 || coding == RRX_MIL8)) ? `RRX_LONG_PRE : `RRX_SHORT_PRE);

  always_comb begin
    ev = 8'h00;
    if (state_r == RRX_SEEK && bit_stb && pre_cnt_r == `RRX_SHORT_PRE - 4'h1 &&
        !(coding == RRX_MIL4 || coding == RRX_MIL8) && rxopt_r[7] == 1'b0)
      ev[`RRX_IRQ_FMT] = 1'b1;
    if (pre_found && !two_byte_header_irq_enable)
      ev[`RRX_IRQ_PRE] = 1'b1;
    if (nr_run_r && nr_units_r == noresp_r && noresp_r != 8'h00)
      ev[`RRX_IRQ_NORESP] = 1'b1;
    if (state_r == RRX_DONE) begin
      ev[`RRX_IRQ_END] = 1'b1;
      ev[`RRX_IRQ_CRC] = !no_crc && (crc_r != `RRX_CRC_RES) && nbits_r >= 16'd16;
      ev[`RRX_IRQ_EOF] = two_byte_header_irq_enable;
    end
    if (wr_fifo && nbytes_r == 16'(`RRX_FIFO_WARN - 1))
      ev[`RRX_IRQ_FIFO] = 1'b1;
    if (wr_fifo && cnt_r == 5'(DEPTH))
      ev[`RRX_IRQ_FMT] = 1'b1;
    if (wr_fifo && two_byte_header_irq_enable && nbytes_r == 16'h0001) begin
      ev[`RRX_IRQ_HDR] = 1'b1;
      ev[`RRX_IRQ_END] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      state_r <= RRX_IDLE;
    else begin
      unique case (state_r)
        RRX_IDLE: if (tx_done) state_r <= RRX_WAIT;
        RRX_WAIT: begin
          if (ev[`RRX_IRQ_NORESP]) state_r <= RRX_IDLE;
          else if (units_r == rxwait_r) state_r <= RRX_SEEK;
        end
        RRX_SEEK: begin
          if (pre_found) state_r <= RRX_DATA;
          else if (ev[`RRX_IRQ_NORESP] || ev[`RRX_IRQ_FMT]) state_r <= RRX_IDLE;
        end
        RRX_DATA: begin
          if (len_eff != 16'h0000 && bit_stb && nbits_r == len_eff - 16'h0001)
            state_r <= RRX_DONE;
          else if (len_eff == 16'h0000 && idle_r == 8'(per_r + `RRX_PAUSE_BITS))
            state_r <= RRX_DONE;
        end
        RRX_DONE: state_r <= RRX_IDLE;
      endcase
    end
  end

  // bit assembly, preamble count and crc
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_r == RRX_IDLE) begin
      pre_cnt_r <= 4'h0;
      bpos_r <= 3'h0;
      byte_r <= 8'h00;
      nbits_r <= 16'h0000;
      crc_r <= `RRX_CRC_INIT;
    end else if (bit_stb && state_r == RRX_SEEK) begin
      pre_cnt_r <= pre_cnt_r + 4'h1;
    end else if (bit_stb && state_r == RRX_DATA) begin
      byte_r <= {byte_r[6:0], bit_val};
      bpos_r <= bpos_r + 3'h1;
      nbits_r <= nbits_r + 16'h0001;
      crc_r <= crc_step(crc_r, bit_val);
    end
  end

  // normal path delays bytes by two so the crc of a reply in whole bytes never reaches the fifo
  wire logic byte_done = bit_stb && state_r == RRX_DATA && bpos_r == 3'h7;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_r == RRX_IDLE) begin
      shift_r <= 16'h0000;
      hold_r <= 16'h0000;
    end else if (byte_done) begin
      shift_r <= {shift_r[7:0], byte_r[6:0], bit_val};
      hold_r <= {hold_r[14:0], 1'b1};
    end
  end

  always_comb begin
    wr_byte = {byte_r[6:0], bit_val};
    wr_fifo = 1'b0;
    if (byte_done) begin
      if (two_byte_header_irq_enable || no_crc)
        wr_fifo = 1'b1;
      else if (hold_r[1]) begin
        wr_fifo = 1'b1;
        wr_byte = shift_r[15:8];
      end
    end
  end

  // partial last byte flushes at the end with its bit count
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      last_byte_valid_bits <= 3'h0;
    else if (state_r == RRX_DONE)
      last_byte_valid_bits <= bpos_r;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_r == RRX_IDLE)
      nbytes_r <= 16'h0000;
    else if (wr_fifo)
      nbytes_r <= nbytes_r + 16'h0001;
  end

  assign rd_fifo = bus.rd && bus.addr == `RRX_ADR_FIFO && cnt_r != 5'h00;
  wire logic flush_part = state_r == RRX_DONE && bpos_r != 3'h0 && cnt_r != 5'(DEPTH);
  wire logic push = (wr_fifo && cnt_r != 5'(DEPTH)) || flush_part;
  always_ff @(posedge sys_clk) begin
    if (push)
      mem[wp_r] <= flush_part ? 8'(byte_r << (4'h8 - {1'b0, bpos_r})) : wr_byte;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst || tx_done) begin
      wp_r <= 5'h00;
      rp_r <= 5'h00;
      cnt_r <= 5'h00;
    end else begin
      if (push) wp_r <= (wp_r == 5'(DEPTH - 1)) ? 5'h00 : wp_r + 5'h01;
      if (rd_fifo) rp_r <= (rp_r == 5'(DEPTH - 1)) ? 5'h00 : rp_r + 5'h01;
      cnt_r <= cnt_r + {4'h0, push} - {4'h0, rd_fifo};
    end
  end

  // rn16 capture; len_force marks a query style command was issued
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      len_force_r <= 16'h0000;
      rn16_cmd_r <= 1'b0;
      rn16_r <= 16'h0000;
    end else begin
      if (bus.wr && bus.addr == `RRX_ADR_CMD) begin
        rn16_cmd_r <= bus.wdata >= 8'h98 && bus.wdata <= 8'h9c;
        if (bus.wdata >= 8'h98 && bus.wdata <= 8'h9c)
          len_force_r <= 16'd16;
        else if (bus.wdata == 8'h9f)
          len_force_r <= 16'd32;
        else
          len_force_r <= 16'h0000;
      end
      if (state_r == RRX_DONE && rn16_cmd_r && nbits_r >= 16'd16)
        rn16_r <= shift_r;
    end
  end

  // status flags: set wins over the read-clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      irq_r <= 8'h00;
    else if (bus.rd && bus.addr == `RRX_ADR_IRQ)
      irq_r <= ev;
    else
      irq_r <= irq_r | ev;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prot_r <= `RRX_PROT_RST;
      rxopt_r <= 8'h00;
      noresp_r <= `RRX_NORESP_DEF;
      rxwait_r <= `RRX_RXWAIT_DEF;
      lenh_r <= 8'h00;
      lenl_r <= 8'h00;
    end else if (bus.wr) begin
      unique case (bus.addr)
        `RRX_ADR_PROT: begin
          prot_r <= bus.wdata;
          rxwait_r <= `RRX_RXWAIT_DEF;
          noresp_r <= `RRX_NORESP_DEF;
        end
        `RRX_ADR_RXOPT: rxopt_r <= bus.wdata;
        `RRX_ADR_NORESP: noresp_r <= bus.wdata;
        `RRX_ADR_RXWAIT: rxwait_r <= bus.wdata;
        `RRX_ADR_LENH: lenh_r <= bus.wdata;
        `RRX_ADR_LENL: lenl_r <= bus.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (bus.rd) begin
      unique case (bus.addr)
        `RRX_ADR_PROT: rdata <= prot_r;
        `RRX_ADR_RXOPT: rdata <= rxopt_r;
        `RRX_ADR_NORESP: rdata <= noresp_r;
        `RRX_ADR_RXWAIT: rdata <= rxwait_r;
        `RRX_ADR_IRQ: rdata <= irq_r;
        `RRX_ADR_LENH: rdata <= lenh_r;
        `RRX_ADR_LENL: rdata <= lenl_r;
        `RRX_ADR_TXLEN2: rdata <= {5'h00, last_byte_valid_bits};
        `RRX_ADR_FIFO: rdata <= mem[rp_r];
        `RRX_ADR_RN16H: rdata <= rn16_r[15:8];
        `RRX_ADR_RN16L: rdata <= rn16_r[7:0];
        `RRX_ADR_FSTAT: rdata <= {3'h0, cnt_r};
        default: rdata <= 8'h00;
      endcase
    end
  end

  // outputs all registered; irq is a level held until the status read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
      direct_out_a <= 1'b0;
      direct_out_b <= 1'b0;
      ack_rn16 <= 16'h0000;
    end else begin
      irq <= (irq_r | ev) != 8'h00 && !(bus.rd && bus.addr == `RRX_ADR_IRQ && ev == 8'h00);
      ack_rn16 <= rn16_r;
      if (direct_en && dir_sel) begin
        direct_out_a <= si_r[1];
        direct_out_b <= sq_r[1];
      end else if (direct_en) begin
        direct_out_a <= bit_val;
        direct_out_b <= bit_stb;
      end else begin
        direct_out_a <= 1'b0;
        direct_out_b <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/rrx_framer_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rrx_defs.svh"
module rrx_framer_checker #(
  parameter int WAIT_CYC = 4,
  parameter int NORESP_CYC = 8,
  parameter int DEPTH = 24
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire rrx_pkg::rrx_bus_type bus,
  input wire logic [7:0] rdata,
  input wire logic tx_done,
  input wire logic direct_en,
  input wire logic irq,
  input wire logic direct_out_a,
  input wire logic direct_out_b,
  input wire logic [15:0] ack_rn16
);
  import rrx_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic status_rd;
  assign status_rd = bus.rd && bus.addr == `RRX_ADR_IRQ;
  sequence s_prot_wr;
    bus.wr && bus.addr == `RRX_ADR_PROT;
  endsequence
  sequence s_rd_at(logic [7:0] a);
    bus.rd && bus.addr == a;
  endsequence
  a_reset_quiet: assert property ($past(sys_rst) |-> !irq && rdata == 8'h00 &&
    ack_rn16 == 16'h0000 && !direct_out_a && !direct_out_b)
    else $error("outputs not cleared after reset");
  a_direct_quiet: assert property (!direct_en ##1 !direct_en |-> !direct_out_a &&
    !direct_out_b)
    else $error("direct outputs active outside direct mode");
  a_flags_behind_irq: assert property (status_rd && irq |=> rdata != 8'h00)
    else $error("irq high but status read empty");
  a_irq_holds_up: assert property (irq && !tx_done && !status_rd && !$past(status_rd)
    |=> irq)
    else $error("irq dropped without a status read");
  a_wait_reloads: assert property (s_prot_wr ##1 s_rd_at(`RRX_ADR_RXWAIT)
    |=> rdata == `RRX_RXWAIT_DEF)
    else $error("wait time not reloaded by protocol write");
  a_noresp_preset: assert property (s_prot_wr ##1 s_rd_at(`RRX_ADR_NORESP)
    |=> rdata == `RRX_NORESP_DEF)
    else $error("no-response count not preset by protocol write");
  a_length_readback: assert property (bus.wr && bus.addr inside {8'h03, 8'h1b}
    ##1 bus.rd && bus.addr == $past(bus.addr) |=> rdata == $past(bus.wdata, 2))
    else $error("register did not keep written value");
  a_unmapped_zero: assert property (bus.rd && !(bus.addr inside {8'h01, 8'h03,
    8'h07, 8'h08, 8'h0c, [8'h1a:8'h23]}) |=> rdata == 8'h00)
    else $error("unmapped read returned data");
endmodule
bind rrx_framer rrx_framer_checker #(.WAIT_CYC(WAIT_CYC), .NORESP_CYC(NORESP_CYC),
  .DEPTH(DEPTH)) u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
  .tx_done(tx_done), .direct_en(direct_en), .irq(irq), .direct_out_a(direct_out_a),
  .direct_out_b(direct_out_b), .ack_rn16(ack_rn16));
`default_nettype wire

// ==== tb/rrx_tag_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rrx_tag_model (
  input wire logic sys_clk,
  input wire logic active,
  input wire logic lvl_i,
  input wire logic lvl_q,
  output logic sub_i,
  output logic sub_q
);
  // a silent tag leaves the digitizer flat; a busy line would pass for a reply
  initial begin
    sub_i = 1'b0;
    sub_q = 1'b0;
  end
  always @(posedge sys_clk) begin
    sub_i <= active ? lvl_i : 1'b0;
    sub_q <= active ? lvl_q : 1'b0;
  end
endmodule
`default_nettype wire

// ==== tb/rrx_framer_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rrx_defs.svh"
module rrx_framer_tb_top;
  import rrx_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  rrx_bus_type bus = '0;
  logic tx_done = 1'b0;
  logic slot_start = 1'b0;
  logic direct_en = 1'b0;
  logic tag_on = 1'b0;
  logic lvl_i = 1'b0;
  logic lvl_q = 1'b0;
  logic sub_i;
  logic sub_q;
  logic [7:0] rdata;
  logic irq;
  logic direct_out_a;
  logic direct_out_b;
  logic [15:0] ack_rn16;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #2 sys_clk = ~sys_clk;
  // short unit counts keep the timers within a few dozen cycles
  rrx_framer #(.WAIT_CYC(4), .NORESP_CYC(8), .DEPTH(24)) dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .sub_i(sub_i), .sub_q(sub_q),
    .tx_done(tx_done), .slot_start(slot_start), .direct_en(direct_en), .irq(irq),
    .direct_out_a(direct_out_a), .direct_out_b(direct_out_b), .ack_rn16(ack_rn16));
  rrx_tag_model tag (.sys_clk(sys_clk), .active(tag_on), .lvl_i(lvl_i), .lvl_q(lvl_q),
    .sub_i(sub_i), .sub_q(sub_q));
  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic end_tx();
    @(posedge sys_clk);
    tx_done <= 1'b1;
    @(posedge sys_clk);
    tx_done <= 1'b0;
  endtask
  // hang guard well above the fifteen hundred or so cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("Error at %0t: run did not finish", $time);
      give_verdict();
    end
  end
  initial begin
    logic [7:0] v;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdchk(`RRX_ADR_PROT, `RRX_PROT_RST);
    rdchk(`RRX_ADR_RXWAIT, `RRX_RXWAIT_DEF);
    rdchk(`RRX_ADR_NORESP, `RRX_NORESP_DEF);
    rdchk(`RRX_ADR_LENH, 8'h00);
    rdchk(8'h55, 8'h00);
    wr(`RRX_ADR_IRQ, 8'hff);
    rdchk(`RRX_ADR_IRQ, 8'h00);
    for (int c = 0; c < 4; c++) begin
      v = {4'h0, 2'(c), 2'b10};
      wr(`RRX_ADR_RXWAIT, 8'h33);
      rdchk(`RRX_ADR_RXWAIT, 8'h33);
      wr(`RRX_ADR_NORESP, 8'h2b);
      wr(`RRX_ADR_PROT, v);
      rdchk(`RRX_ADR_PROT, v);
      rdchk(`RRX_ADR_RXWAIT, `RRX_RXWAIT_DEF);
      rdchk(`RRX_ADR_NORESP, `RRX_NORESP_DEF);
    end
    wr(`RRX_ADR_LENH, 8'h80);
    rdchk(`RRX_ADR_LENH, 8'h80);
    wr(`RRX_ADR_LENH, 8'h00);
    wr(`RRX_ADR_LENL, 8'h10);
    rdchk(`RRX_ADR_LENL, 8'h10);
    // empty slot: two units of eight cycles with no reply
    wr(`RRX_ADR_NORESP, 8'h02);
    @(posedge sys_clk);
    tx_done <= 1'b1;
    @(posedge sys_clk);
    tx_done <= 1'b0;
    slot_start <= 1'b1;
    @(posedge sys_clk);
    slot_start <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    check(8'(irq), 8'h00);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check(8'(irq), 8'h01);
    rdchk(`RRX_ADR_IRQ, 8'h01 << `RRX_IRQ_NORESP);
    @(posedge sys_clk);
    #1;
    check(8'(irq), 8'h00);
    rdchk(`RRX_ADR_IRQ, 8'h00);
    // raw channels routed straight out when the select bit is high
    wr(`RRX_ADR_PROT, 8'h46);
    direct_en <= 1'b1;
    tag_on <= 1'b1;
    lvl_i <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    check(8'({direct_out_a, direct_out_b}), 8'h02);
    lvl_i <= 1'b0;
    lvl_q <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    check(8'({direct_out_a, direct_out_b}), 8'h01);
    direct_en <= 1'b0;
    tag_on <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check(8'({direct_out_a, direct_out_b}), 8'h00);
    // forced 16 bit reply on a flat line decodes as all ones and lands whole in the fifo
    wr(`RRX_ADR_PROT, 8'h08);
    wr(`RRX_ADR_CMD, 8'h9c);
    tag_on <= 1'b1;
    lvl_i <= 1'b1;
    end_tx();
    repeat (500) @(posedge sys_clk);
    #1;
    check(8'(irq), 8'h01);
    rdchk(`RRX_ADR_IRQ, (8'h01 << `RRX_IRQ_END) | (8'h01 << `RRX_IRQ_PRE));
    rdchk(`RRX_ADR_FSTAT, 8'h02);
    rdchk(`RRX_ADR_FIFO, 8'hff);
    rdchk(`RRX_ADR_FIFO, 8'hff);
    rdchk(`RRX_ADR_RN16H, 8'hff);
    check(ack_rn16[7:0], 8'hff);
    // header mode with crc off: the host answers the two byte interrupt mid-reply
    wr(`RRX_ADR_CMD, 8'h00);
    wr(`RRX_ADR_PROT, 8'h88);
    wr(`RRX_ADR_LENH, 8'h80);
    wr(`RRX_ADR_LENL, 8'h18);
    end_tx();
    for (int i = 0; i < 600 && irq !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    rdchk(`RRX_ADR_IRQ, 8'h48);
    rdchk(`RRX_ADR_FIFO, 8'hff);
    rdchk(`RRX_ADR_FIFO, 8'hff);
    wr(`RRX_ADR_LENH, 8'h80);
    wr(`RRX_ADR_LENL, 8'h20);
    repeat (400) @(posedge sys_clk);
    #1;
    check(8'(irq), 8'h01);
    rdchk(`RRX_ADR_IRQ, 8'h42);
    rdchk(`RRX_ADR_FSTAT, 8'h02);
    rdchk(`RRX_ADR_TXLEN2, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
